// ==== testbench/motor_algo_config_regs_chk.sv ====
// Port-level assertions for the algorithm tuning bank.
// Assumes it is bound onto motor_algo_config_regs.
`timescale 1ns/10ps
`default_nettype none
module motor_algo_config_regs_chk (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Detection sources
   input wire logic [1:0] normal_detect_current_threshold,
   input wire logic [1:0] meas_detect_current_limit,
   // Decoded parameters
   input wire logic [3:0] prealign_closed_loop_accel,
   input wire logic [2:0] brake_bus_slew,
   input wire logic brake_slew_unlimited,
   input wire logic detect_param_source_sel,
   input wire logic [2:0] detect_current_limit,
   input wire logic backemf_param_source_sel,
   input wire logic position_detect_hires_en
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // Completed accesses, held by the master until pready
   wire done = psel && penable && pready;
   wire wr_tun = done && pwrite && paddr == 12'h288;
   wire rd_hole = done && !pwrite && !(paddr inside {12'h288, 12'h380, 12'h388, 12'h3c0, 12'h3c4});
   a_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("no answer after one wait state");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_unlim_code: assert property (brake_slew_unlimited == (brake_bus_slew == 3'h7))
      else $error("unlimited flag disagrees with slew code");
   a_accel_write: assert property (wr_tun |=> prealign_closed_loop_accel == $past(pwdata[9:6]))
      else $error("acceleration code not taken from write");
   a_slew_write: assert property (wr_tun |=> brake_bus_slew == $past(pwdata[5:3]))
      else $error("brake slew code not taken from write");
   a_sel_write: assert property (wr_tun |=>
      {detect_param_source_sel, backemf_param_source_sel, position_detect_hires_en} == $past(pwdata[2:0]))
      else $error("selector bits not taken from write");
   a_detect_limit: assert property (!$past(reset) |-> detect_current_limit ==
      {1'b0, detect_param_source_sel ? $past(meas_detect_current_limit) : $past(normal_detect_current_threshold)})
      else $error("detection limit from wrong source");
   a_hole_zero: assert property (rd_hole |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_no_error: assert property (pready |-> !pslverr)
      else $error("error response seen");
   c_write: cover property (wr_tun);
   c_hole: cover property (rd_hole);
   c_meas: cover property (detect_param_source_sel && backemf_param_source_sel);
endmodule
bind motor_algo_config_regs motor_algo_config_regs_chk i_chk (.clock, .reset, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .normal_detect_current_threshold, .meas_detect_current_limit,
   .prealign_closed_loop_accel, .brake_bus_slew, .brake_slew_unlimited, .detect_param_source_sel,
   .detect_current_limit, .backemf_param_source_sel, .position_detect_hires_en);
`default_nettype wire

// ==== testbench/motor_algo_config_regs_tb.sv ====
// Self-checking bench for the tuning bank over its bus port.
// Assumes the checker file is compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module motor_algo_config_regs_tb;
   logic clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
   wire pready, pslverr, irq;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, q, tun, prm = 0, dfr = 0, cfr = 0;
   wire [31:0] prdata, dec;
   logic [11:0] ad [5] = '{12'h288, 12'h380, 12'h388, 12'h3c0, 12'h3c4};
   int failures = 0, check_count = 0, seed, i;
   // Half period of 25 ns
   always #25 clock = ~clock;
   motor_algo_config_regs i_dut (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .driver_fault_raw(dfr), .control_fault_raw(cfr), .normal_detect_current_threshold(prm[1:0]),
      .normal_detect_repeat_count(prm[4:2]), .meas_detect_current_limit(prm[6:5]),
      .meas_detect_repeat_count(prm[8:7]), .openloop_accel_coef_one(prm[12:9]),
      .openloop_accel_coef_two(prm[16:13]), .normal_openloop_current_ref(prm[19:17]),
      .normal_handoff_speed(prm[23:20]), .meas_openloop_slew(prm[26:24]), .meas_openloop_current_ref(prm[29:27]),
      .meas_openloop_speed_target(prm[31:30]), .prealign_closed_loop_accel(dec[31:28]),
      .brake_bus_slew(dec[27:25]), .brake_slew_unlimited(dec[24]), .detect_param_source_sel(dec[23]),
      .detect_current_limit(dec[22:20]), .detect_repeat(dec[19:17]), .backemf_param_source_sel(dec[16]),
      .backemf_slew(dec[15:8]), .backemf_current_ref(dec[7:5]), .backemf_speed_ref(dec[4:1]),
      .position_detect_hires_en(dec[0]), .irq(irq));
   // Decoded outputs expected from a tuning word and the packed sources
   function automatic [31:0] exp_dec(input [31:0] t, input [31:0] p);
      exp_dec = {t[9:6], t[5:3], t[5:3] == 3'h7, t[2], 1'b0, t[2] ? p[6:5] : p[1:0],
         t[2] ? {1'b0, p[8:7]} : p[4:2], t[1], t[1] ? {5'h0, p[26:24]} : {p[16:13], p[12:9]},
         t[1] ? p[29:27] : p[19:17], t[1] ? {2'h0, p[31:30]} : p[23:20], t[0]};
   endfunction
   task automatic results;
      if (failures == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input [31:0] g, input [31:0] e);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // One transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input [11:0] a, input [31:0] d);
      int n;
      @(posedge clock);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      psel <= 0;
      penable <= 0;
      if (pready !== 1'b1) begin
         failures++;
         results;
      end
   endtask
   task automatic rd(input [11:0] a, input [31:0] e);
      apb(0, a, 0);
      chk(q, e);
   endtask
   // Interrupt wait, bounded so a dead line cannot hang the run
   task automatic wait_irq(input logic v);
      int n;
      n = 0;
      while (irq !== v && n < 20) begin
         @(posedge clock);
         n++;
      end
      chk({31'h0, irq}, {31'h0, v});
      if (irq !== v)
         results;
   endtask
   initial begin
      seed = 70754;
      repeat (20) @(posedge clock);
      reset <= 0;
      foreach (ad[k]) rd(ad[k], 0);
      // All-ones and no-limit corners, then random words
      for (i = 0; i < 12; i++) begin
         tun = i == 0 ? 32'hffffffff : i == 1 ? 32'h38 : $random(seed);
         prm <= $random(seed);
         apb(1, 12'h288, tun);
         rd(12'h288, tun);
         repeat (2) @(posedge clock);
         chk(dec, exp_dec(tun, prm));
      end
      dfr <= $random(seed) | 32'h1;
      cfr <= $random(seed) | 32'h1;
      repeat (8) @(posedge clock);
      rd(12'h380, dfr);
      rd(12'h388, cfr);
      apb(1, 12'h380, ~dfr);
      rd(12'h380, dfr);
      apb(1, 12'h004, 32'hffffffff);
      rd(12'h004, 0);
      rd(12'h288, tun);
      // Events latched while masked, then unmasked and cleared
      rd(12'h3c0, 32'h3);
      wait_irq(0);
      apb(1, 12'h3c4, 1);
      wait_irq(1);
      apb(1, 12'h3c0, 1);
      wait_irq(0);
      rd(12'h3c0, 32'h2);
      apb(1, 12'h3c4, 3);
      wait_irq(1);
      apb(1, 12'h3c0, 2);
      wait_irq(0);
      rd(12'h3c0, 0);
      dfr <= 0;
      repeat (8) @(posedge clock);
      dfr <= 32'h1;
      wait_irq(1);
      rd(12'h3c0, 32'h1);
      results;
   end
endmodule
`default_nettype wire

// ==== verilog/fault_input_sync.v ====
// Three-stage synchroniser with agreement filter for one bus of fault lines.
// Assumes the lines come from outside the clock domain.
`timescale 1ns/10ps
`default_nettype none
module fault_input_sync #(
   parameter WIDTH = 32
) (
   // Clock and reset
   input wire clock,
   input wire reset,
   // Raw and filtered lines
   input wire [WIDTH-1:0] raw,
   output reg [WIDTH-1:0] clean
);
   reg [WIDTH-1:0] stage1_reg;
   reg [WIDTH-1:0] stage2_reg;
   reg [WIDTH-1:0] stage3_reg;
   genvar i;
   // Stage one feeds only stage two; change counts once two and three agree
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always @(posedge clock or posedge reset) begin
            if (reset) begin
               stage1_reg[i] <= 1'b0;
               stage2_reg[i] <= 1'b0;
               stage3_reg[i] <= 1'b0;
               clean[i] <= 1'b0;
            end else begin
               stage1_reg[i] <= raw[i];
               stage2_reg[i] <= stage1_reg[i];
               stage3_reg[i] <= stage2_reg[i];
               if (stage2_reg[i] == stage3_reg[i]) begin
                  clean[i] <= stage3_reg[i];
               end
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ==== verilog/motor_algo_config_regs.v ====
// APB register bank: algorithm tuning register, two read-only fault words,
// event status and mask with one interrupt line.
// Assumes an APB master on clock; fault words arrive asynchronously on pins.
//
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "motor_algo_config_regs_consts.vh"
module motor_algo_config_regs (
   // Clock and reset
   input wire clock,
   input wire reset,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Raw fault lines from the protection circuits
   input wire [31:0] driver_fault_raw,
   input wire [31:0] control_fault_raw,
   // Parameter sources from neighbouring registers
   input wire [1:0] normal_detect_current_threshold,
   input wire [2:0] normal_detect_repeat_count,
   input wire [1:0] meas_detect_current_limit,
   input wire [1:0] meas_detect_repeat_count,
   input wire [3:0] openloop_accel_coef_one,
   input wire [3:0] openloop_accel_coef_two,
   input wire [2:0] normal_openloop_current_ref,
   input wire [3:0] normal_handoff_speed,
   input wire [2:0] meas_openloop_slew,
   input wire [2:0] meas_openloop_current_ref,
   input wire [1:0] meas_openloop_speed_target,
   // Parameters to the algorithm
   output reg [3:0] prealign_closed_loop_accel,
   output reg [2:0] brake_bus_slew,
   output reg brake_slew_unlimited,
   output reg detect_param_source_sel,
   output reg [2:0] detect_current_limit,
   output reg [2:0] detect_repeat,
   output reg backemf_param_source_sel,
   output reg [7:0] backemf_slew,
   output reg [2:0] backemf_current_ref,
   output reg [3:0] backemf_speed_ref,
   output reg position_detect_hires_en,
   // Interrupt
   output reg irq
);
   // Register storage
   reg [31:0] algorithm_tuning_second_reg;
   reg [31:0] driver_fault_flags_reg;
   reg [31:0] control_fault_flags_reg;
   reg [1:0] event_status_reg;
   reg [1:0] event_mask_reg;

   // Combinational next values for the event word and read data
   reg [1:0] event_status_next;
   reg [31:0] read_next;
   reg hit_next;

   // Fault words after the synchronisers
   wire [31:0] driver_clean;
   wire [31:0] control_clean;

   // Decoded fields from the selection leaf
   wire [3:0] accel_code;
   wire [2:0] slew_code;
   wire slew_unlimited;
   wire detect_sel;
   wire [2:0] limit_code;
   wire [2:0] repeat_code;
   wire backemf_sel;
   wire [7:0] bemf_slew_code;
   wire [2:0] bemf_current_code;
   wire [3:0] bemf_speed_code;
   wire hires;

   // Bus decode
   wire access;
   wire wr;
   wire rd;
   wire wr_tuning;
   wire wr_status;
   wire wr_mask;

   // Rising edge of each fault word, one bit per event
   wire [1:0] fault_rise;

   // Fault pins cross into the clock domain before anyone looks at them
   fault_input_sync #(
      .WIDTH(32)
   ) u_driver_sync (
      .clock(clock),
      .reset(reset),
      .raw(driver_fault_raw),
      .clean(driver_clean)
   );

   // Same filter for the controller-side fault word
   fault_input_sync #(
      .WIDTH(32)
   ) u_control_sync (
      .clock(clock),
      .reset(reset),
      .raw(control_fault_raw),
      .clean(control_clean)
   );

   // Field decode and parameter source selection
   param_select u_select (
      .tuning(algorithm_tuning_second_reg),
      .normal_detect_current_threshold(normal_detect_current_threshold),
      .normal_detect_repeat_count(normal_detect_repeat_count),
      .meas_detect_current_limit(meas_detect_current_limit),
      .meas_detect_repeat_count(meas_detect_repeat_count),
      .openloop_accel_coef_one(openloop_accel_coef_one),
      .openloop_accel_coef_two(openloop_accel_coef_two),
      .normal_openloop_current_ref(normal_openloop_current_ref),
      .normal_handoff_speed(normal_handoff_speed),
      .meas_openloop_slew(meas_openloop_slew),
      .meas_openloop_current_ref(meas_openloop_current_ref),
      .meas_openloop_speed_target(meas_openloop_speed_target),
      .accel_code(accel_code),
      .brake_slew_code(slew_code),
      .brake_slew_unlimited(slew_unlimited),
      .detect_use_meas(detect_sel),
      .detect_limit_code(limit_code),
      .detect_repeat_code(repeat_code),
      .backemf_use_meas(backemf_sel),
      .backemf_slew_code(bemf_slew_code),
      .backemf_current_code(bemf_current_code),
      .backemf_speed_code(bemf_speed_code),
      .hires_en(hires)
   );

   // Access phase of an APB transfer; one wait state, then a ready pulse
   assign access = psel & penable & ~pready;
   assign wr = access & pwrite;
   assign rd = access & ~pwrite;

   // One write strobe per writable word; anything else is dropped here
   assign wr_tuning = wr & (paddr == `ADDR_ALGO_TUNING_SECOND);
   assign wr_status = wr & (paddr == `ADDR_EVENT_STATUS);
   assign wr_mask = wr & (paddr == `ADDR_EVENT_MASK);

   // A fault word going from clear to non-clear is an event
   assign fault_rise[`EV_DRIVER_FAULT] = (|driver_clean) & ~(|driver_fault_flags_reg);
   assign fault_rise[`EV_CONTROL_FAULT] = (|control_clean) & ~(|control_fault_flags_reg);

   // Sticky events: write-one clears, but a new event in the same cycle wins
   // Clear first, then set, so a same-cycle event is never lost
   always @* begin
      event_status_next = event_status_reg;
      if (wr_status) begin
         event_status_next = event_status_reg & ~pwdata[1:0];
      end
      event_status_next = event_status_next | fault_rise;
   end

   // Read mux; unlisted addresses read zero and flag a miss
   // A miss never raises an error, software just sees zero
   always @* begin
      read_next = 32'h00000000;
      hit_next = 1'b1;
      case (paddr)
         `ADDR_ALGO_TUNING_SECOND: begin
            read_next = algorithm_tuning_second_reg;
         end
         `ADDR_DRIVER_FAULT_FLAGS: begin
            read_next = driver_fault_flags_reg;
         end
         `ADDR_CONTROL_FAULT_FLAGS: begin
            read_next = control_fault_flags_reg;
         end
         `ADDR_EVENT_STATUS: begin
            read_next = {30'h00000000, event_status_reg};
         end
         `ADDR_EVENT_MASK: begin
            read_next = {30'h00000000, event_mask_reg};
         end
         default: begin
            hit_next = 1'b0;
         end
      endcase
   end

   // Handshake: one wait state, then a single-cycle ready pulse
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= access;
         pslverr <= 1'b0;
      end
   end

   // Read data loads on reads only, so it holds until the next one
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         prdata <= 32'h00000000;
      end else begin
         if (rd) begin
            prdata <= hit_next ? read_next : 32'h00000000;
         end
      end
   end

   // Tuning word; reserved upper bits are kept as written but drive nothing
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         algorithm_tuning_second_reg <= `RST_ALGO_TUNING_SECOND;
      end else begin
         if (wr_tuning) begin
            algorithm_tuning_second_reg <= pwdata;
         end
      end
   end

   // Event mask, same layout as the event word
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         event_mask_reg <= `RST_EVENT;
      end else begin
         if (wr_mask) begin
            event_mask_reg <= pwdata[1:0];
         end
      end
   end

   // Fault words mirror the synchronised pins; writes never reach them
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         driver_fault_flags_reg <= `RST_FAULT_FLAGS;
         control_fault_flags_reg <= `RST_FAULT_FLAGS;
      end else begin
         driver_fault_flags_reg <= driver_clean;
         control_fault_flags_reg <= control_clean;
      end
   end

   // Event word and interrupt line move on the same edge
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         event_status_reg <= `RST_EVENT;
         irq <= 1'b0;
      end else begin
         event_status_reg <= event_status_next;
         irq <= |(event_status_next & event_mask_reg);
      end
   end

   // Fields taken straight from the tuning word, one cycle behind it
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         prealign_closed_loop_accel <= 4'h0;
         brake_bus_slew <= 3'h0;
         brake_slew_unlimited <= 1'b0;
         detect_param_source_sel <= 1'b0;
         backemf_param_source_sel <= 1'b0;
         position_detect_hires_en <= 1'b0;
      end else begin
         prealign_closed_loop_accel <= accel_code;
         brake_bus_slew <= slew_code;
         brake_slew_unlimited <= slew_unlimited;
         detect_param_source_sel <= detect_sel;
         backemf_param_source_sel <= backemf_sel;
         position_detect_hires_en <= hires;
      end
   end

   // Parameters steered by the two selectors
   // Both sets stay live inputs; the selector only picks which one is passed on
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         detect_current_limit <= 3'h0;
         detect_repeat <= 3'h0;
         backemf_slew <= 8'h00;
         backemf_current_ref <= 3'h0;
         backemf_speed_ref <= 4'h0;
      end else begin
         detect_current_limit <= limit_code;
         detect_repeat <= repeat_code;
         backemf_slew <= bemf_slew_code;
         backemf_current_ref <= bemf_current_code;
         backemf_speed_ref <= bemf_speed_code;
      end
   end
endmodule
`default_nettype wire

// ==== verilog/motor_algo_config_regs_consts.vh ====
// Register map, field positions, reset values and interrupt layout for the
// motor algorithm configuration bank. Included by the bank and its param_select leaf.
`ifndef MOTOR_ALGO_CONFIG_REGS_CONSTS_VH
`define MOTOR_ALGO_CONFIG_REGS_CONSTS_VH
// Printed offsets are register indices; byte address is four times the index
`define IDX_ALGO_TUNING_SECOND 8'ha2
`define IDX_DRIVER_FAULT_FLAGS 8'he0
`define IDX_CONTROL_FAULT_FLAGS 8'he2
`define IDX_EVENT_STATUS 8'hf0
`define IDX_EVENT_MASK 8'hf1
`define ADDR_ALGO_TUNING_SECOND 12'h288
`define ADDR_DRIVER_FAULT_FLAGS 12'h380
`define ADDR_CONTROL_FAULT_FLAGS 12'h388
`define ADDR_EVENT_STATUS 12'h3c0
`define ADDR_EVENT_MASK 12'h3c4
// Reset values
`define RST_ALGO_TUNING_SECOND 32'h00000000
`define RST_FAULT_FLAGS 32'h00000000
`define RST_EVENT 2'h0
// Field positions inside the tuning register
`define ACCEL_MSB 9
`define ACCEL_LSB 6
`define BRAKE_SLEW_MSB 5
`define BRAKE_SLEW_LSB 3
`define DETECT_SEL_BIT 2
`define BACKEMF_SEL_BIT 1
`define HIRES_BIT 0
// Brake slew code that removes the limit
`define BRAKE_SLEW_NO_LIMIT 3'h7
// Event bits
`define EV_DRIVER_FAULT 0
`define EV_CONTROL_FAULT 1
`endif

// ==== verilog/param_select.v ====
// Decodes the tuning register into the parameters the algorithm consumes.
// Assumes both parameter sets arrive as plain inputs from other registers.
`timescale 1ns/10ps
`default_nettype none
`include "motor_algo_config_regs_consts.vh"
module param_select (
   // Tuning word
   input wire [31:0] tuning,
   // Normal detection set
   input wire [1:0] normal_detect_current_threshold,
   input wire [2:0] normal_detect_repeat_count,
   // Measurement detection set
   input wire [1:0] meas_detect_current_limit,
   input wire [1:0] meas_detect_repeat_count,
   // Normal back-EMF set
   input wire [3:0] openloop_accel_coef_one,
   input wire [3:0] openloop_accel_coef_two,
   input wire [2:0] normal_openloop_current_ref,
   input wire [3:0] normal_handoff_speed,
   // Measurement back-EMF set
   input wire [2:0] meas_openloop_slew,
   input wire [2:0] meas_openloop_current_ref,
   input wire [1:0] meas_openloop_speed_target,
   // Decoded outputs
   output wire [3:0] accel_code,
   output wire [2:0] brake_slew_code,
   output wire brake_slew_unlimited,
   output wire detect_use_meas,
   output wire [2:0] detect_limit_code,
   output wire [2:0] detect_repeat_code,
   output wire backemf_use_meas,
   output wire [7:0] backemf_slew_code,
   output wire [2:0] backemf_current_code,
   output wire [3:0] backemf_speed_code,
   output wire hires_en
);
   // Plain field extraction
   assign accel_code = tuning[`ACCEL_MSB:`ACCEL_LSB];
   assign brake_slew_code = tuning[`BRAKE_SLEW_MSB:`BRAKE_SLEW_LSB];
   assign brake_slew_unlimited = (brake_slew_code == `BRAKE_SLEW_NO_LIMIT);
   assign hires_en = tuning[`HIRES_BIT];
   // Detection source choice
   assign detect_use_meas = tuning[`DETECT_SEL_BIT];
   assign detect_limit_code = detect_use_meas ? {1'b0, meas_detect_current_limit} :
                              {1'b0, normal_detect_current_threshold};
   assign detect_repeat_code = detect_use_meas ? {1'b0, meas_detect_repeat_count} :
                               normal_detect_repeat_count;
   // Back-EMF source choice; normal slew is the two coefficients side by side
   assign backemf_use_meas = tuning[`BACKEMF_SEL_BIT];
   assign backemf_slew_code = backemf_use_meas ? {5'h00, meas_openloop_slew} :
                              {openloop_accel_coef_two, openloop_accel_coef_one};
   assign backemf_current_code = backemf_use_meas ? meas_openloop_current_ref :
                                 normal_openloop_current_ref;
   assign backemf_speed_code = backemf_use_meas ? {2'h0, meas_openloop_speed_target} :
                               normal_handoff_speed;
endmodule
`default_nettype wire
